// ### pkg/crc_engine_pkg.sv
// Overview of operation
// [R01] write transpose field bits 31:30 reshapes every value written to the checksum
// [R02] read transpose field bits 29:28 reshapes checksum reads, same four encodings
// [R03] control bit 27 and low reserved bits read zero, writes ignored
// [R04] read complement bit 26 inverts every checksum read
// [R05] seed select bit 25: checksum writes load seed, else fold data
// [R06] control bit 24 picks 16-bit or 32-bit checksum width
// [R07] data writes of 8, 16 or 32 bits accepted; bytes must be contiguous
// [R08] 16-bit mode keeps the running checksum in the low 16 bits
// [R09] 32-bit mode keeps the running checksum in all 32 bits
// [R10] 16-bit seed write loads only the low 16 bits
// [R11] 16-bit mode uses only the low polynomial half
// [R12] data folded one byte at a time, two clocks per byte
// [R13] narrow writes transposed as zero-extended word, only valid bytes folded
// [R14] 16-bit result with read transpose 10 or 11 lands in upper half
// [R15] transposes act on the fly, never alter stored checksum; off by default
// [R16] setting seed select and writing a seed restarts the checksum
// [R17] software sets width, polynomial, transposes, complement, then seed, then data
// [R18] checksum reads always return the current intermediate value
// [R19] 16-bit mode ignores writes to the upper polynomial half
// [R20] non-reflected shift register, top byte first, polynomial xor on carry-out
package crc_engine_pkg;
    localparam logic [3:0] data_offset = 4'h0;
    localparam logic [3:0] poly_offset = 4'h4;
    localparam logic [3:0] ctrl_offset = 4'h8;
    localparam logic [3:0] status_offset = 4'hC;

    localparam logic [31:0] data_reset = 32'hFFFF_FFFF;
    localparam logic [31:0] poly_reset = 32'h0000_1021;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;

    localparam int wr_tp_lsb = 30;
    localparam int rd_tp_lsb = 28;
    localparam int complement_bit = 26;
    localparam int seed_bit = 25;
    localparam int width_bit = 24;
    localparam int busy_bit = 0;

    localparam logic [1:0] size_8 = 2'h0;
    localparam logic [1:0] size_16 = 2'h1;
    localparam logic [1:0] size_32 = 2'h2;

    localparam logic [1:0] tp_none = 2'h0;
    localparam logic [1:0] tp_bits = 2'h1;
    localparam logic [1:0] tp_both = 2'h2;
    localparam logic [1:0] tp_bytes = 2'h3;

    typedef enum logic [0:0] {engine_idle, engine_busy} engine_state_t;
endpackage

// ### design/programmable_crc_engine.sv
`timescale 1ns/10ps
module programmable_crc_engine (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic [1:0] bus_size,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [31:0] bus_rdata,
    output logic crc_busy
);
    logic rst_meta;
    logic rst_sync_n;
    logic [31:0] checksum;
    logic [31:0] polynomial_register;
    logic [1:0] write_transpose_sel;
    logic [1:0] read_transpose_sel;
    logic read_complement_en;
    logic seed_write_sel;
    logic width_32_sel;
    logic [31:0] work;
    logic [2:0] bytes_left;
    logic phase;
    crc_engine_pkg::engine_state_t state;

    logic [31:0] next_checksum;
    logic [31:0] next_polynomial_register;
    logic [1:0] next_write_transpose_sel;
    logic [1:0] next_read_transpose_sel;
    logic next_read_complement_en;
    logic next_seed_write_sel;
    logic next_width_32_sel;
    logic [31:0] next_work;
    logic [2:0] next_bytes_left;
    logic next_phase;
    crc_engine_pkg::engine_state_t next_state;
    logic [31:0] next_bus_rdata;
    logic next_crc_busy;

    logic [31:0] write_word;
    logic [31:0] read_word;
    logic [2:0] valid_bytes;

    function automatic logic [31:0] transpose(input logic [31:0] v, input logic [1:0] sel);
        logic [31:0] bitrev;
        bitrev = '0;
        for (int i = 0; i < 32; i++) begin
            bitrev[i] = v[31 - i];
        end
        case (sel)
            crc_engine_pkg::tp_bits: transpose = {bitrev[7:0], bitrev[15:8], bitrev[23:16], bitrev[31:24]};
            crc_engine_pkg::tp_both: transpose = bitrev;
            crc_engine_pkg::tp_bytes: transpose = {v[7:0], v[15:8], v[23:16], v[31:24]};
            default: transpose = v;
        endcase
    endfunction

    function automatic logic [31:0] fold_byte(input logic [31:0] crc, input logic [7:0] b,
                                               input logic [31:0] poly, input logic wide);
        logic [31:0] c;
        c = crc;
        if (wide) begin
            c = c ^ {b, 24'h00_0000};
            for (int i = 0; i < 8; i++) begin
                c = c[31] ? ({c[30:0], 1'b0} ^ poly) : {c[30:0], 1'b0}; // R20
            end
        end else begin
            c[15:0] = c[15:0] ^ {b, 8'h00};
            for (int i = 0; i < 8; i++) begin
                c[15:0] = c[15] ? ({c[14:0], 1'b0} ^ poly[15:0]) : {c[14:0], 1'b0}; // R11
            end
        end
        fold_byte = c;
    endfunction

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    always_comb begin
        case (bus_size)
            crc_engine_pkg::size_8: write_word = {24'h00_0000, bus_wdata[7:0]};
            crc_engine_pkg::size_16: write_word = {16'h0000, bus_wdata[15:0]};
            default: write_word = bus_wdata;
        endcase
        write_word = transpose(write_word, write_transpose_sel); // R01 R13
        case (bus_size)
            crc_engine_pkg::size_8: valid_bytes = 3'd1;
            crc_engine_pkg::size_16: valid_bytes = 3'd2;
            default: valid_bytes = 3'd4; // R07
        endcase
        read_word = read_complement_en ? ~checksum : checksum; // R04
        read_word = transpose(read_word, read_transpose_sel); // R02 R14 R15
    end

    always_comb begin
        next_checksum = checksum;
        next_polynomial_register = polynomial_register;
        next_write_transpose_sel = write_transpose_sel;
        next_read_transpose_sel = read_transpose_sel;
        next_read_complement_en = read_complement_en;
        next_seed_write_sel = seed_write_sel;
        next_width_32_sel = width_32_sel;
        next_work = work;
        next_bytes_left = bytes_left;
        next_phase = phase;
        next_state = state;
        next_bus_rdata = 32'h0000_0000;

        case (state)
            crc_engine_pkg::engine_busy: begin
                next_phase = ~phase; // R12
                if (phase) begin
                    next_checksum = fold_byte(checksum, work[31:24], polynomial_register, width_32_sel); // R08 R09
                    next_work = {work[23:0], 8'h00};
                    next_bytes_left = bytes_left - 3'd1;
                    if (bytes_left == 3'd1) begin
                        next_state = crc_engine_pkg::engine_idle;
                    end
                end
            end
            default: next_state = crc_engine_pkg::engine_idle;
        endcase

        if (bus_write) begin
            case (bus_addr)
                crc_engine_pkg::data_offset: begin
                    if (state == crc_engine_pkg::engine_idle) begin
                        if (seed_write_sel) begin
                            if (width_32_sel) begin
                                next_checksum = write_word; // R05 R16
                            end else begin
                                next_checksum[15:0] = write_word[15:0]; // R10
                            end
                        end else begin
                            // valid bytes are aligned to the top before folding
                            if (write_transpose_sel[1]) begin
                                next_work = write_word; // R13
                            end else begin
                                next_work = write_word << (6'((3'd4 - valid_bytes)) * 6'd8);
                            end
                            next_bytes_left = valid_bytes;
                            next_phase = 1'b0;
                            next_state = crc_engine_pkg::engine_busy; // R05
                        end
                    end
                end
                crc_engine_pkg::poly_offset: begin
                    next_polynomial_register[15:0] = bus_wdata[15:0];
                    if (width_32_sel) begin
                        next_polynomial_register[31:16] = bus_wdata[31:16]; // R19
                    end
                end
                crc_engine_pkg::ctrl_offset: begin
                    next_write_transpose_sel = bus_wdata[crc_engine_pkg::wr_tp_lsb +: 2];
                    next_read_transpose_sel = bus_wdata[crc_engine_pkg::rd_tp_lsb +: 2];
                    next_read_complement_en = bus_wdata[crc_engine_pkg::complement_bit];
                    next_seed_write_sel = bus_wdata[crc_engine_pkg::seed_bit];
                    next_width_32_sel = bus_wdata[crc_engine_pkg::width_bit]; // R06
                end
                default: begin
                end
            endcase
        end

        if (bus_read) begin
            case (bus_addr)
                crc_engine_pkg::data_offset: next_bus_rdata = read_word; // R18
                crc_engine_pkg::poly_offset: next_bus_rdata = polynomial_register;
                crc_engine_pkg::ctrl_offset: begin
                    next_bus_rdata[crc_engine_pkg::wr_tp_lsb +: 2] = write_transpose_sel;
                    next_bus_rdata[crc_engine_pkg::rd_tp_lsb +: 2] = read_transpose_sel;
                    next_bus_rdata[crc_engine_pkg::complement_bit] = read_complement_en;
                    next_bus_rdata[crc_engine_pkg::seed_bit] = seed_write_sel;
                    next_bus_rdata[crc_engine_pkg::width_bit] = width_32_sel; // R03
                end
                crc_engine_pkg::status_offset: begin
                    next_bus_rdata[crc_engine_pkg::busy_bit] = (state == crc_engine_pkg::engine_busy);
                end
                default: next_bus_rdata = 32'h0000_0000;
            endcase
        end
        next_crc_busy = (next_state == crc_engine_pkg::engine_busy);
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            checksum <= crc_engine_pkg::data_reset;
            polynomial_register <= crc_engine_pkg::poly_reset;
            write_transpose_sel <= crc_engine_pkg::ctrl_reset[crc_engine_pkg::wr_tp_lsb +: 2]; // R15
            read_transpose_sel <= crc_engine_pkg::ctrl_reset[crc_engine_pkg::rd_tp_lsb +: 2];
            read_complement_en <= crc_engine_pkg::ctrl_reset[crc_engine_pkg::complement_bit];
            seed_write_sel <= crc_engine_pkg::ctrl_reset[crc_engine_pkg::seed_bit];
            width_32_sel <= crc_engine_pkg::ctrl_reset[crc_engine_pkg::width_bit];
            work <= 32'h0000_0000;
            bytes_left <= 3'd0;
            phase <= 1'b0;
            state <= crc_engine_pkg::engine_idle;
            bus_rdata <= 32'h0000_0000;
            crc_busy <= 1'b0;
        end else begin
            checksum <= next_checksum;
            polynomial_register <= next_polynomial_register;
            write_transpose_sel <= next_write_transpose_sel;
            read_transpose_sel <= next_read_transpose_sel;
            read_complement_en <= next_read_complement_en;
            seed_write_sel <= next_seed_write_sel;
            width_32_sel <= next_width_32_sel;
            work <= next_work;
            bytes_left <= next_bytes_left;
            phase <= next_phase;
            state <= next_state;
            bus_rdata <= next_bus_rdata;
            crc_busy <= next_crc_busy;
        end
    end
endmodule

// ### bench/crc_engine_asserts.sv
`timescale 1ns/10ps
module crc_engine_asserts (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic [1:0] bus_size,
    input wire logic bus_write,
    input wire logic bus_read,
    input wire logic [31:0] bus_rdata,
    input wire logic crc_busy
);
    logic [31:0] ctl;
    logic [31:0] next_ctl;
    logic go;
    always_comb begin
        next_ctl = ctl;
        if (bus_write && bus_addr == 4'h8) begin
            next_ctl = bus_wdata & 32'hF700_0000;
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctl <= 32'h0000_0000;
        end else begin
            ctl <= next_ctl;
        end
    end
    assign go = bus_write && bus_addr == 4'h0 && !crc_busy;
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // two busy cycles per folded byte
    sequence run2; crc_busy [*2] ##1 !crc_busy; endsequence
    sequence run4; crc_busy [*4] ##1 !crc_busy; endsequence
    sequence run8; crc_busy [*8] ##1 !crc_busy; endsequence
    a_rdata_quiet: assert property (!$past(bus_read) |-> bus_rdata == 32'h0000_0000)
        else $error("read data not zero outside read slot");
    a_fold_start: assert property (go && !ctl[25] |=> crc_busy)
        else $error("data write did not start folding");
    a_fold_byte: assert property (go && !ctl[25] && bus_size == 2'h0 |=> run2)
        else $error("byte fold length wrong");
    a_fold_half: assert property (go && !ctl[25] && bus_size == 2'h1 |=> run4)
        else $error("halfword fold length wrong");
    a_fold_word: assert property (go && !ctl[25] && bus_size[1] |=> run8)
        else $error("word fold length wrong");
    a_status_busy: assert property (bus_read && bus_addr == 4'hC |=> bus_rdata[31:1] == 31'h0000_0000 && bus_rdata[0] == $past(crc_busy))
        else $error("status busy bit wrong");
    a_seed_quiet: assert property (go && ctl[25] |=> !crc_busy)
        else $error("seed write caused folding");
    a_ctrl_echo: assert property (bus_read && bus_addr == 4'h8 |=> bus_rdata == $past(ctl))
        else $error("control readback wrong");
    a_hole_zero: assert property (bus_read && bus_addr[1:0] != 2'h0 |=> bus_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule

// ### bench/programmable_crc_engine_tb.sv
`timescale 1ns/10ps
module programmable_crc_engine_tb;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] bus_addr = 4'h0;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic [1:0] bus_size = 2'h2;
    logic bus_write = 1'b0;
    logic bus_read = 1'b0;
    logic [31:0] bus_rdata;
    logic crc_busy;
    logic rush = 1'b0;
    int bad_count = 0;
    int checked = 0;
    logic [31:0] m_crc = 32'hFFFF_FFFF;
    logic [31:0] m_poly = 32'h0000_1021;
    logic [31:0] m_ctrl = 32'h0000_0000;
    logic [31:0] got;
    programmable_crc_engine dut (.ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_size(bus_size), .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .crc_busy(crc_busy));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] tp(logic [31:0] v, logic [1:0] m);
        logic [31:0] r;
        logic [31:0] t;
        r = {<<{v}};
        case (m)
            2'h1: t = {<<8{r}};
            2'h2: t = r;
            2'h3: t = {<<8{v}};
            default: t = v;
        endcase
        return t;
    endfunction
    function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] b, logic [31:0] p, logic w);
        logic [31:0] x;
        x = w ? c ^ {b, 24'h0} : {c[31:16], c[15:0] ^ {b, 8'h00}};
        for (int i = 0; i < 8; i++) begin
            if (w) x = x[31] ? (x << 1) ^ p : x << 1;
            else x[15:0] = x[15] ? (x[15:0] << 1) ^ p[15:0] : x[15:0] << 1;
        end
        return x;
    endfunction
    task automatic end_sim();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(logic [31:0] e, logic [31:0] a);
        checked++;
        if (a !== e) begin
            bad_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic idle();
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            #1;
            if (crc_busy === 1'b0) return;
        end
        bad_count++;
        end_sim();
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] s);
        @(posedge ref_clk);
        bus_write <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        bus_size <= s;
        @(posedge ref_clk);
        bus_write <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        bus_read <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_read <= 1'b0;
        #1 v = bus_rdata;
    endtask
    // model update, then the bus write
    task automatic put(logic [3:0] a, logic [31:0] d, logic [1:0] s);
        logic [31:0] w;
        int n;
        n = s == 2'h0 ? 1 : s == 2'h1 ? 2 : 4;
        w = tp(n == 4 ? d : d & ((32'h1 << (8 * n)) - 1), m_ctrl[31:30]);
        if (a == 4'h8) m_ctrl = d & 32'hF700_0000;
        else if (a == 4'h4) m_poly = m_ctrl[24] ? d : {m_poly[31:16], d[15:0]};
        else if (m_ctrl[25]) m_crc = m_ctrl[24] ? w : {m_crc[31:16], w[15:0]};
        else for (int k = 0; k < n; k++)
            m_crc = fold(m_crc, m_ctrl[31] ? w[31 - 8 * k -: 8] : w[8 * n - 1 - 8 * k -: 8], m_poly, m_ctrl[24]);
        wr(a, d, s);
        if (a == 4'h0 && !rush) idle();
    endtask
    initial begin
        void'($urandom(32'h2644));
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(4'h0, got);
        chk(32'hFFFF_FFFF, got);
        rd(4'h4, got);
        chk(32'h0000_1021, got);
        rd(4'h8, got);
        chk(32'h0000_0000, got);
        for (int t = 0; t < 60; t++) begin
            put(4'h8, $urandom() | 32'h0200_0000, 2'h2);
            put(4'h4, $urandom(), 2'h2);
            rd(4'h8, got);
            chk(m_ctrl, got);
            put(4'h0, $urandom(), 2'h2);
            put(4'h8, m_ctrl & 32'hFDFF_FFFF, 2'h2);
            // back-to-back write lands while busy and is dropped
            if (t % 4 == 0) begin
                rush = 1'b1;
                put(4'h0, $urandom(), 2'h2);
                wr(4'h0, $urandom(), 2'h2);
                rd(4'hC, got);
                chk(32'h0000_0001, got);
                rush = 1'b0;
                idle();
                rd(4'hC, got);
                chk(32'h0000_0000, got);
            end
            repeat (1 + $urandom() % 3) put(4'h0, $urandom(), 2'($urandom() % 3));
            rd(4'h0, got);
            chk(tp(m_ctrl[26] ? ~m_crc : m_crc, m_ctrl[29:28]), got);
            rd(4'h4, got);
            chk(m_poly, got);
            rd(4'h2, got);
            chk(32'h0000_0000, got);
        end
        end_sim();
    end
endmodule
bind programmable_crc_engine crc_engine_asserts chk_inst (.ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_size(bus_size), .bus_write(bus_write), .bus_read(bus_read),
    .bus_rdata(bus_rdata), .crc_busy(crc_busy));
